// *** verilog/bpfc_pkg.sv ***
// Shared constants and carrier types of the boost PFC control block
package bpfc_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int MIN_OFF_NS = 600;
	localparam int MIN_OFF_CYC = (MIN_OFF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int SYNC_TIMEOUT_US = 108;
	localparam int SYNC_TIMEOUT_CYC = SYNC_TIMEOUT_US * (CLK_HZ / 1_000_000);
	localparam int SYNC_LOCK_PULSES = 6;
	localparam int SAMPLE_HZ = 3550;
	localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
	localparam int INT_PERIOD_CYC = 154;

	// ************************************************************
	// Voltage loop
	// ************************************************************
	localparam int WORD_W = 9;
	localparam logic [8:0] WORD_FULL = 9'h100;
	localparam logic [8:0] WORD_INIT = 9'h000;
	localparam logic [11:0] VREF_CODE = 12'h800;
	localparam int SS_STEP_CYC = 64;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic supplyAboveStart;
		logic supplyAboveStop;
		logic bulkAboveMin;
		logic setPinAbove;
		logic syncPulse;
		logic rampCross;
		logic peakCurrentLimit;
		logic outputAbove95;
	} bpfc_cmp_type;

	typedef struct packed {
		logic gateOn;
		logic rampDischarge;
		logic forceCompNode;
		logic [8:0] controlWord;
	} bpfc_drive_type;

endpackage

// *** verilog/bpfc_sync2.sv ***
// Two-stage synchroniser for a bus of comparator levels
module bpfc_sync2 #(
	parameter int W = 8
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);
	logic [W-1:0] stage1_ff;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stage1_ff <= '0;
			syncOut <= '0;
		end
		else
		begin
			stage1_ff <= asyncIn;
			syncOut <= stage1_ff;
		end
	end
endmodule

// *** verilog/bpfc_voltage_loop.sv ***
// Notch filter and PI compensator of the sampled outer voltage loop
module bpfc_voltage_loop (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clear,
	input wire logic sampleValid,
	input wire logic [11:0] sampleCode,
	input wire logic softStart,
	output logic [8:0] controlWord_ff
);
	logic [11:0] dly1_ff;
	logic [11:0] dly2_ff;
	logic [15:0] integ_ff;
	logic [8:0] ssLimit_ff;
	logic [5:0] ssDiv_ff;
	logic signed [13:0] filtered;
	logic signed [13:0] errVal;
	logic signed [17:0] sumVal;
	logic [8:0] piWord;

	// Comb at two samples rejects the double-line ripple, passes slow change
	always_comb
	begin
		filtered = $signed({2'b00, sampleCode}) + $signed({2'b00, dly2_ff});
		filtered = filtered >>> 1;
		errVal = $signed({2'b00, bpfc_pkg::VREF_CODE}) - filtered;
		sumVal = $signed({2'b00, integ_ff}) + 18'(errVal >>> 2);
		if (sumVal < 0)
			piWord = '0;
		else if (sumVal[17:7] > 11'(bpfc_pkg::WORD_FULL))
			piWord = bpfc_pkg::WORD_FULL;
		else
			piWord = sumVal[15:7];
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dly1_ff <= '0;
			dly2_ff <= '0;
		end
		else if (sampleValid)
		begin
			dly1_ff <= sampleCode;
			dly2_ff <= dly1_ff;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			integ_ff <= '0;
		else if (clear)
			integ_ff <= '0;
		else if (sampleValid && sumVal >= 0 && sumVal < 18'sh10000)
			integ_ff <= 16'(sumVal);
	end

	// soft-start limit ramps up from the initial word
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ssLimit_ff <= bpfc_pkg::WORD_INIT;
			ssDiv_ff <= '0;
		end
		else if (clear)
		begin
			ssLimit_ff <= bpfc_pkg::WORD_INIT;
			ssDiv_ff <= '0;
		end
		else
		begin
			ssDiv_ff <= ssDiv_ff + 6'h01;
			if (ssDiv_ff == 6'h3f && ssLimit_ff < bpfc_pkg::WORD_FULL)
				ssLimit_ff <= ssLimit_ff + 9'h001;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			controlWord_ff <= bpfc_pkg::WORD_INIT;
		else if (clear)
			controlWord_ff <= bpfc_pkg::WORD_INIT;
		else if (softStart && piWord > ssLimit_ff)
			controlWord_ff <= ssLimit_ff;
		else
			controlWord_ff <= piWord;
	end
endmodule

// *** verilog/bpfc_pwm_control.sv ***
// Top of the boost PFC control: supply gating, oscillator, sync, PWM
//
// Summary of operation
// - Start when supply and bulk both qualify
// - Supply below stop threshold shuts down
// - Low bulk-sense input forces standby
// - Soft-start ramps loop output until 95%
// - Set-pin high: lock after six pulses
// - Synced cycle starts on external rising edge
// - Pulse gap over timeout reverts internal
// - Bulk sense sampled at fixed rate
// - Notch removes double-line ripple
// - PI compensator gives bounded control word
// - Cycle opens with minimum off interval
// - Ramp crossing turns gate on
// - Standby forces compensation node high
// - Off interval resets both latches first
// - Peak limit holds gate off for rest of cycle
module bpfc_pwm_control #(
	parameter int INT_PERIOD = bpfc_pkg::INT_PERIOD_CYC
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire bpfc_pkg::bpfc_cmp_type cmpIn,
	input wire logic [11:0] bulkSampleCode,
	output bpfc_pkg::bpfc_drive_type driveOut,
	output logic running,
	output logic syncLocked,
	output logic sampleStrobe
);
	// Period must leave room for the off interval and fit the counter
	if (INT_PERIOD <= bpfc_pkg::MIN_OFF_CYC + 1 || INT_PERIOD > 65535)
	begin : g_period_check
		$error("INT_PERIOD out of range");
	end

	// ************************************************************
	// Input synchronisation
	// ************************************************************
	bpfc_pkg::bpfc_cmp_type cmp;

	bpfc_sync2 #(
		.W($bits(bpfc_pkg::bpfc_cmp_type))
	) u_sync (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.asyncIn(cmpIn),
		.syncOut(cmp)
	);

	// ************************************************************
	// Supply qualification
	// ************************************************************
	typedef enum logic [1:0] {ST_OFF, ST_STANDBY, ST_RUN} bpfc_state_type;
	bpfc_state_type state_ff;
	bpfc_state_type nxt_state;
	logic softStart_ff;
	logic restart;

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_OFF:
				if (cmp.supplyAboveStart && cmp.bulkAboveMin)
					nxt_state = ST_RUN;
				else if (cmp.supplyAboveStart)
					nxt_state = ST_STANDBY;
			ST_STANDBY:
				if (!cmp.supplyAboveStop)
					nxt_state = ST_OFF;
				else if (cmp.bulkAboveMin)
					nxt_state = ST_RUN;
			ST_RUN:
				if (!cmp.supplyAboveStop)
					nxt_state = ST_OFF;
				else if (!cmp.bulkAboveMin)
					nxt_state = ST_STANDBY;
			default:
				nxt_state = ST_OFF;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			state_ff <= ST_OFF;
		else
			state_ff <= nxt_state;
	end

	assign running = (state_ff == ST_RUN);
	// restart pulse on entry to run
	assign restart = (nxt_state == ST_RUN) && (state_ff != ST_RUN);

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			softStart_ff <= 1'b1;
		else if (!running)
			softStart_ff <= 1'b1;
		else if (cmp.outputAbove95)
			softStart_ff <= 1'b0;
	end

	// ************************************************************
	// Voltage loop sampling
	// ************************************************************
	logic [15:0] sampleCnt_ff;

	// sample tick at the converter rate
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			sampleCnt_ff <= '0;
		else if (sampleCnt_ff == 16'(bpfc_pkg::SAMPLE_CYC - 1))
			sampleCnt_ff <= '0;
		else
			sampleCnt_ff <= sampleCnt_ff + 16'h0001;
	end

	assign sampleStrobe = (sampleCnt_ff == 16'h0000) && running;

	logic [8:0] controlWord;

	bpfc_voltage_loop u_vloop (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.clear(!running),
		.sampleValid(sampleStrobe),
		.sampleCode(bulkSampleCode),
		.softStart(softStart_ff),
		.controlWord_ff(controlWord)
	);

	// ************************************************************
	// Oscillator and external sync
	// ************************************************************
	logic pulseDly_ff;
	logic pulseRise;
	logic [2:0] pulseCnt_ff;
	logic [15:0] gapCnt_ff;
	logic [15:0] oscCnt_ff;
	logic locked_ff;
	logic cycleStart;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			pulseDly_ff <= 1'b0;
		else
			pulseDly_ff <= cmp.syncPulse;
	end

	assign pulseRise = cmp.syncPulse && !pulseDly_ff;

	// count pulses while set pin is high
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			pulseCnt_ff <= '0;
		// The first edge after a long gap still counts as pulse one
		else if (restart || !cmp.setPinAbove || !locked_ff && !pulseRise &&
				gapCnt_ff == 16'(bpfc_pkg::SYNC_TIMEOUT_CYC))
			pulseCnt_ff <= '0;
		else if (pulseRise && pulseCnt_ff < 3'(bpfc_pkg::SYNC_LOCK_PULSES))
			pulseCnt_ff <= pulseCnt_ff + 3'h1;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			gapCnt_ff <= '0;
		else if (pulseRise)
			gapCnt_ff <= '0;
		else if (gapCnt_ff != 16'(bpfc_pkg::SYNC_TIMEOUT_CYC))
			gapCnt_ff <= gapCnt_ff + 16'h0001;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			locked_ff <= 1'b0;
		else if (restart || !cmp.setPinAbove ||
				gapCnt_ff == 16'(bpfc_pkg::SYNC_TIMEOUT_CYC))
			locked_ff <= 1'b0;
		else if (pulseCnt_ff == 3'(bpfc_pkg::SYNC_LOCK_PULSES))
			locked_ff <= 1'b1;
	end

	assign syncLocked = locked_ff;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			oscCnt_ff <= '0;
		else if (cycleStart)
			oscCnt_ff <= '0;
		else
			oscCnt_ff <= oscCnt_ff + 16'h0001;
	end

	// synced cycle starts on external rising edge
	// Compare with >= so a count left high by a lost lock wraps at once
	assign cycleStart = locked_ff ? pulseRise :
		(oscCnt_ff >= 16'(INT_PERIOD - 1));

	// ************************************************************
	// PWM logic
	// ************************************************************
	logic [3:0] offCnt_ff;
	logic minOff;
	logic onLatch_ff;
	logic limitLatch_ff;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			offCnt_ff <= '0;
		// The start cycle itself is the first cycle of the interval
		else if (cycleStart)
			offCnt_ff <= 4'(bpfc_pkg::MIN_OFF_CYC - 1);
		else if (offCnt_ff != 4'h0)
			offCnt_ff <= offCnt_ff - 4'h1;
	end

	assign minOff = (offCnt_ff != 4'h0) || cycleStart;

	// reset has top priority, latch limit
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			limitLatch_ff <= 1'b0;
		else if (minOff)
			limitLatch_ff <= 1'b0;
		else if (cmp.peakCurrentLimit)
			limitLatch_ff <= 1'b1;
	end

	// ramp crossing turns the gate on
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			onLatch_ff <= 1'b0;
		else if (minOff)
			onLatch_ff <= 1'b0;
		else if (cmp.rampCross && running)
			onLatch_ff <= 1'b1;
	end

	logic gateOn;

	// gate off at once on peak limit
	// gate off from the very start cycle
	assign gateOn = onLatch_ff && !limitLatch_ff &&
		!cmp.peakCurrentLimit && running && !minOff;
	assign driveOut = '{gateOn: gateOn, rampDischarge: minOff,
		forceCompNode: !running, controlWord: controlWord};

	// ************************************************************
	// Checks
	// ************************************************************
	sequence s_offStart;
		cycleStart ##1 (offCnt_ff == 4'(bpfc_pkg::MIN_OFF_CYC - 1));
	endsequence

	a_min_off: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_offStart |-> !driveOut.gateOn [*5])
		else $error("gate on inside minimum off interval");
	a_latch_reset: assert property (@(posedge sys_clk) disable iff (!arst_n)
		cycleStart |=> !onLatch_ff && !limitLatch_ff)
		else $error("latches not reset by off interval");
	a_limit_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		limitLatch_ff |-> !driveOut.gateOn)
		else $error("gate on after peak limit");
	a_supply_lockout_stop: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!cmp.supplyAboveStop |=> !running ##1 !driveOut.gateOn)
		else $error("run after supply lockout");
	a_standby_force: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(running && !cmp.bulkAboveMin) |=> driveOut.forceCompNode)
		else $error("standby not forcing node");
	a_start_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
		$rose(running) |-> $past(cmp.supplyAboveStart) && $past(cmp.bulkAboveMin))
		else $error("start without qualification");
	a_sync_drop: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(gapCnt_ff == 16'(bpfc_pkg::SYNC_TIMEOUT_CYC)) |=> !locked_ff)
		else $error("lock kept after timeout");
	a_sync_lock: assert property (@(posedge sys_clk) disable iff (!arst_n)
		$rose(locked_ff) |-> $past(pulseCnt_ff) == 3'(bpfc_pkg::SYNC_LOCK_PULSES))
		else $error("lock before six pulses");
	a_sync_edge: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(locked_ff && pulseRise) |=>
		(offCnt_ff == 4'(bpfc_pkg::MIN_OFF_CYC - 1)))
		else $error("synced cycle not on pulse edge");
	a_soft_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
		$rose(running) |-> driveOut.controlWord == bpfc_pkg::WORD_INIT)
		else $error("restart not from initial word");
	a_pulse_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
		restart |=> (pulseCnt_ff == 3'h0) && !locked_ff)
		else $error("sync count kept over restart");
endmodule

// *** tb/bpfc_partner_model.sv ***
// Far-side model: external sync pulse source and boost stage ramp crossing
module bpfc_partner_model (
	input wire logic sys_clk,
	input wire logic syncEnable,
	input wire logic rampDischarge,
	input wire logic [7:0] rampDelay,
	output logic syncPulse,
	output logic rampCross
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SYNC_PERIOD = 50;
	int syncCnt = 0;
	int rampCnt = 0;
	initial
	begin
		syncPulse = 1'b0;
		rampCross = 1'b0;
	end
	always @(posedge sys_clk)
	begin
		syncCnt <= syncEnable ? (syncCnt + 1) % SYNC_PERIOD : 0;
		syncPulse <= #1 syncEnable && (syncCnt < 2);
	end
	// Ramp meets the averaged current a set time after discharge ends
	always @(posedge sys_clk)
	begin
		rampCnt <= rampDischarge ? 0 : rampCnt + 1;
		rampCross <= #1 !rampDischarge && (rampCnt >= int'(rampDelay));
	end
endmodule

// *** tb/tb_boost_pfc_pwm_sync_control.sv ***
// Self-checking bench of the boost PFC control top
module tb_boost_pfc_pwm_sync_control;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	bpfc_pkg::bpfc_cmp_type cmpDrv = '0;
	bpfc_pkg::bpfc_drive_type driveOut;
	logic running, syncLocked, sampleStrobe, syncPulse, rampCross;
	logic syncEnable = 1'b0;
	logic [7:0] rampDelay = 8'h05;
	logic [11:0] bulkCode = 12'h700;
	logic [11:0] strobeGap = 12'h000;
	int strobeCnt = 0;
	int seed = 32'h63e1c2f4;
	int nFail = 0;
	int numChecks = 0;
	int qKind[$];
	logic [11:0] qExp[$];
	string names[8] = '{"running", "gateOn", "forceCompNode", "syncLocked",
		"rampDischarge", "controlWord", "wordInRange", "strobeGap"};

	always #50 sys_clk = ~sys_clk;

	bpfc_pwm_control #(.INT_PERIOD(40)) bpfc_pwm_control_i (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.cmpIn({cmpDrv[7:4], syncPulse, rampCross, cmpDrv[1:0]}),
		.bulkSampleCode(bulkCode),
		.driveOut(driveOut),
		.running(running),
		.syncLocked(syncLocked),
		.sampleStrobe(sampleStrobe)
	);

	bpfc_partner_model bpfc_partner_model_i (
		.sys_clk(sys_clk),
		.syncEnable(syncEnable),
		.rampDischarge(driveOut.rampDischarge),
		.rampDelay(rampDelay),
		.syncPulse(syncPulse),
		.rampCross(rampCross)
	);

	function automatic logic [11:0] observe(input int k);
		case (k)
			0: observe = {11'h000, running};
			1: observe = {11'h000, driveOut.gateOn};
			2: observe = {11'h000, driveOut.forceCompNode};
			3: observe = {11'h000, syncLocked};
			4: observe = {11'h000, driveOut.rampDischarge};
			5: observe = {3'h0, driveOut.controlWord};
			6: observe = {11'h000, driveOut.controlWord != 9'h000 &&
				driveOut.controlWord <= bpfc_pkg::WORD_FULL};
			7: observe = strobeGap;
			8: observe = {11'h000, sampleStrobe};
			9: observe = {11'h000, syncPulse};
			default: observe = {11'h000, !driveOut.rampDischarge};
		endcase
	endfunction

	// Interval between converter sample strobes
	always @(posedge sys_clk)
	begin
		if (sampleStrobe)
		begin
			strobeGap <= strobeCnt[11:0];
			strobeCnt <= 1;
		end
		else
			strobeCnt <= strobeCnt + 1;
	end

	// Watcher: settled outputs are compared with the oldest notes
	always @(negedge sys_clk)
	begin
		while (qKind.size() > 0)
		begin
			int k;
			logic [11:0] e;
			logic [11:0] s;
			k = qKind.pop_front();
			e = qExp.pop_front();
			s = observe(k);
			numChecks++;
			if (s !== e)
			begin
				nFail++;
				$display("mismatch %s expected %0h seen %0h", names[k], e, s);
			end
		end
	end

	// Converter codes near the reference, refreshed every cycle
	always @(posedge sys_clk)
		#2 bulkCode = 12'h700 + 12'($unsigned($random(seed)) % 64);

	task note(input int k, input int v);
		qKind.push_back(k);
		qExp.push_back(12'(v));
	endtask

	task tick(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask

	task waitHigh(input int k);
		int n;
		n = 0;
		while (observe(k) !== 12'h001 && n < 3000)
		begin
			tick(1);
			n++;
		end
		if (n == 3000)
		begin
			nFail++;
			$display("mismatch wait%0d expected 1 seen 0", k);
		end
	endtask

	task endOfTest;
		$display("checks %0d mismatches %0d", numChecks, nFail);
		if (nFail == 0 && numChecks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (30000) @(posedge sys_clk);
		nFail++;
		endOfTest;
	end

	initial
	begin
		tick(3);
		arst_n = 1'b1;
		note(0, 0); note(2, 1); note(1, 0); note(5, 0);
		cmpDrv.supplyAboveStart = 1'b1;
		cmpDrv.supplyAboveStop = 1'b1;
		tick(6);
		note(0, 0);
		cmpDrv.bulkAboveMin = 1'b1;
		tick(6);
		note(0, 1); note(2, 0); note(5, 0);
		tick(1000);
		note(6, 1);
		waitHigh(8);
		tick(1);
		waitHigh(8);
		tick(1);
		note(7, 12'(bpfc_pkg::SAMPLE_CYC));
		cmpDrv.outputAbove95 = 1'b1;
		repeat (4)
		begin
			rampDelay = 8'(3 + $unsigned($random(seed)) % 6);
			// Wait for a fresh interval, never land inside one
			waitHigh(10);
			waitHigh(4);
			note(1, 0);
			repeat (5)
			begin
				tick(1);
				note(4, 1); note(1, 0);
			end
			waitHigh(10);
			tick(int'(rampDelay) + 7);
			note(1, 1);
			cmpDrv.peakCurrentLimit = 1'b1;
			tick(3);
			cmpDrv.peakCurrentLimit = 1'b0;
			tick(1);
			note(1, 0);
			tick(5);
			note(1, 0);
		end
		cmpDrv.setPinAbove = 1'b1;
		syncEnable = 1'b1;
		tick(245);
		note(3, 0);
		tick(15);
		note(3, 1);
		waitHigh(9);
		tick(4);
		note(4, 1);
		tick(40);
		note(4, 0);
		waitHigh(9);
		syncEnable = 1'b0;
		tick(1050);
		note(3, 1);
		tick(60);
		note(3, 0);
		waitHigh(10);
		waitHigh(4);
		tick(40);
		note(4, 1);
		cmpDrv.supplyAboveStart = 1'b0;
		tick(6);
		note(0, 1);
		cmpDrv.supplyAboveStop = 1'b0;
		tick(6);
		note(0, 0); note(1, 0);
		cmpDrv.supplyAboveStart = 1'b1;
		cmpDrv.supplyAboveStop = 1'b1;
		tick(6);
		note(0, 1); note(5, 0);
		cmpDrv.bulkAboveMin = 1'b0;
		tick(6);
		note(0, 0); note(2, 1); note(1, 0);
		tick(2);
		endOfTest;
	end
endmodule
